// [design/sdl_top.sv]
// Transceiver channel loopback selection, signal detect and clock-recovery lock status
`timescale 1ns/1ps
package sdl_pkg;
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  OFS_LOOPBACK  = 4'h0;
    localparam logic [3:0]  OFS_PMA_CTRL0 = 4'h4;
    localparam logic [3:0]  OFS_PMA_STAT  = 4'h8;
    localparam logic [3:0]  OFS_MODE      = 4'hC;
    localparam int          LB_A_BIT      = 0;
    localparam int          LB_C_BIT      = 1;
    localparam int          LB_B_BIT      = 2;
    localparam int          LB_NEAR_BIT   = 0;
    localparam int          LB_FAR_BIT    = 1;
    localparam int          C0_CDR_EN_BIT = 0;
    localparam int          C0_THR_BIT    = 1;
    localparam int          C0_DRIFT_BIT  = 2;
    localparam int          C0_FDSET_BIT  = 3;
    localparam int          ST_TDET_BIT   = 2;
    localparam int          ST_CDRLOL_BIT = 3;
    localparam int          ST_TXLOL_BIT  = 4;
    localparam int          ST_REFLOL_BIT = 5;
    localparam int          ST_FDMIS_BIT  = 6;
    localparam int          MODE_66B_BIT  = 0;
    localparam logic [2:0]  LOOPBACK_RST  = 3'h0;
    localparam logic [3:0]  PMA_CTRL0_RST = 4'h1;
    localparam logic [0:0]  MODE_RST      = 1'h1;
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          FREQ_LOCK_NS  = 15000;
    localparam int          COARSE_NS     = 500;
    localparam int          FINE_WAIT_NS  = 250;
    localparam int          FREQ_CYC      = (FREQ_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          COARSE_CYC    = (COARSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          FINE_CYC      = (FINE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Frequency deviation in units of 0.01 percent
    localparam logic [7:0]  FD_THR_SET0   = 8'h31;
    localparam logic [7:0]  FD_THR_SET1   = 8'h62;
    typedef enum logic [3:0]
    {
        CDR_OFF    = 4'b0001,
        CDR_FREQ   = 4'b0010,
        CDR_COARSE = 4'b0100,
        CDR_FINE   = 4'b1000
    } sdl_cdr_t;
endpackage
module sdl_top
    import sdl_pkg::*;
#(
    parameter int LB_FIFO_DEPTH = 4
)
(
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [ADDR_W-1:0] WB_ADR,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK,
    input  wire logic [63:0] TX_XG_DATA,
    input  wire logic [7:0]  TX_XG_CTRL,
    input  wire logic [63:0] RX_DEC_DATA,
    input  wire logic [7:0]  RX_DEC_CTRL,
    output logic      [63:0] RX_FIFO_DATA,
    output logic      [7:0]  RX_FIFO_CTRL,
    output logic      [63:0] TX_FIFO_DATA,
    output logic      [7:0]  TX_FIFO_CTRL,
    input  wire logic [15:0] TX_PCS_WORD,
    input  wire logic [15:0] RX_DES_WORD,
    output logic      [15:0] RX_PCS_WORD,
    output logic      [15:0] TX_SER_WORD,
    output logic             RX_PATH_ON_TX_CLK,
    input  wire logic        RX_ABOVE_125,
    input  wire logic        RX_ABOVE_180,
    input  wire logic        TXPLL_LOCK,
    input  wire logic        REFCLK_OK,
    input  wire logic [7:0]  FREQ_DEV,
    output logic             RECOVERED_CLOCK_RUN,
    output logic             DRIFT_RANGE_WIDE,
    output logic             CDR_LOCKED
);
    // =====================================================================
    // Pin synchronisers
    localparam int SYNC_W = 12;
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_q;
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sync_meta <= '0;
            sync_q    <= '0;
        end
        else
        begin
            sync_meta <= {FREQ_DEV, REFCLK_OK, TXPLL_LOCK, RX_ABOVE_180, RX_ABOVE_125};
            sync_q    <= sync_meta;
        end
    end
    logic       above_125;
    logic       above_180;
    logic       txpll_lock;
    logic       refclk_ok;
    logic [7:0] freq_dev;
    assign {freq_dev, refclk_ok, txpll_lock, above_180, above_125} = sync_q;
    // =====================================================================
    // Wishbone slave
    logic [2:0] loopback_control_reg;
    logic [3:0] pma_control_zero;
    logic [0:0] mode_cfg;
    logic [6:0] pma_status_reg;
    logic       req;
    logic       wr_now;
    assign req    = WB_CYC && WB_STB;
    assign wr_now = req && WB_ACK && WB_WE && WB_SEL[0];

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            WB_ACK <= 1'b0;
        else
            WB_ACK <= req && !WB_ACK;
    end

    // Read data is latched with the ack so it stands for the whole answer cycle
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            WB_DAT_O <= 32'h0000_0000;
        else if (req && !WB_ACK && !WB_WE)
        begin
            unique case (WB_ADR)
                OFS_LOOPBACK:  WB_DAT_O <= {29'h0, loopback_control_reg};
                OFS_PMA_CTRL0: WB_DAT_O <= {28'h0, pma_control_zero};
                OFS_PMA_STAT:  WB_DAT_O <= {25'h0, pma_status_reg};
                OFS_MODE:      WB_DAT_O <= {31'h0, mode_cfg};
                default:       WB_DAT_O <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            loopback_control_reg <= LOOPBACK_RST;
            pma_control_zero     <= PMA_CTRL0_RST;
            mode_cfg             <= MODE_RST;
        end
        else if (wr_now)
        begin
            if (WB_ADR == OFS_LOOPBACK)
                loopback_control_reg <= WB_DAT_I[2:0];
            if (WB_ADR == OFS_PMA_CTRL0)
                pma_control_zero <= WB_DAT_I[3:0];
            if (WB_ADR == OFS_MODE)
                mode_cfg <= WB_DAT_I[0:0];
        end
    end
    // =====================================================================
    // Loopback selection
    logic mode_66b;
    logic lb_a;
    logic lb_b;
    logic lb_c;
    logic lb_near;
    logic lb_far;
    assign mode_66b = mode_cfg[MODE_66B_BIT];
    assign lb_a     = mode_66b && loopback_control_reg[LB_A_BIT];
    assign lb_b     = mode_66b && loopback_control_reg[LB_B_BIT];
    assign lb_c     = mode_66b && loopback_control_reg[LB_C_BIT];
    assign lb_near  = !mode_66b && loopback_control_reg[LB_NEAR_BIT];
    assign lb_far   = !mode_66b && loopback_control_reg[LB_FAR_BIT];

    // Tells the clock tree to run the receive path from the transmit PCS clock
    assign RX_PATH_ON_TX_CLK = lb_a;

    // Phase compensation FIFO; one clock here, so it only absorbs the start-up skew
    localparam int PTR_W = $clog2(LB_FIFO_DEPTH);
    logic [15:0]      lb_mem [LB_FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   lb_count;
    logic             lb_rd;
    assign lb_rd = lb_a && (lb_count != '0);

    always_ff @(posedge MCLK)
    begin
        if (lb_a)
            lb_mem[wr_ptr] <= TX_PCS_WORD;
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            lb_count <= '0;
        end
        else
        begin
            // Pointers fall back to empty whenever path A is off
            wr_ptr   <= lb_a ? PTR_W'(wr_ptr + 1'b1) : '0;
            rd_ptr   <= lb_rd ? PTR_W'(rd_ptr + 1'b1) : (lb_a ? rd_ptr : '0);
            lb_count <= !lb_a ? '0 : (lb_rd ? lb_count : (PTR_W+1)'(lb_count + 1'b1));
        end
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            RX_PCS_WORD  <= 16'h0000;
            TX_SER_WORD  <= 16'h0000;
            RX_FIFO_DATA <= 64'h0000_0000_0000_0000;
            RX_FIFO_CTRL <= 8'h00;
            TX_FIFO_DATA <= 64'h0000_0000_0000_0000;
            TX_FIFO_CTRL <= 8'h00;
        end
        else
        begin
            if (lb_a)
                RX_PCS_WORD <= lb_rd ? lb_mem[rd_ptr] : 16'h0000;
            else if (lb_near)
                RX_PCS_WORD <= TX_PCS_WORD;
            else
                RX_PCS_WORD <= RX_DES_WORD;
            // No bit skipping here: both ends must share one reference clock
            TX_SER_WORD  <= lb_far ? RX_DES_WORD : TX_PCS_WORD;
            RX_FIFO_DATA <= lb_b ? TX_XG_DATA : RX_DEC_DATA;
            RX_FIFO_CTRL <= lb_b ? TX_XG_CTRL : RX_DEC_CTRL;
            TX_FIFO_DATA <= lb_c ? RX_DEC_DATA : TX_XG_DATA;
            TX_FIFO_CTRL <= lb_c ? RX_DEC_CTRL : TX_XG_CTRL;
        end
    end
    // =====================================================================
    // Signal detector
    logic tdet;
    logic over_thr;
    assign over_thr = pma_control_zero[C0_THR_BIT] ? above_180 : above_125;
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            tdet <= 1'b0;
        else if (over_thr)
            tdet <= 1'b1;
    end
    // =====================================================================
    // Clock-recovery lock controller
    sdl_cdr_t   cdr_state;
    sdl_cdr_t   next_cdr_state;
    logic [8:0] lock_cnt;
    logic       fd_mismatch;
    logic       fine_settled;
    logic       cdr_run;
    assign cdr_run      = pma_control_zero[C0_CDR_EN_BIT] && refclk_ok;
    assign fine_settled = (cdr_state == CDR_FINE) && (lock_cnt >= 9'(FINE_CYC));
    // Thresholds sit mid-way in the band where a mismatch is optional
    assign fd_mismatch  = freq_dev > (pma_control_zero[C0_FDSET_BIT] ? FD_THR_SET1
                                                                    : FD_THR_SET0);

    always_comb
    begin
        next_cdr_state = cdr_state;
        unique case (cdr_state)
            CDR_OFF:
                next_cdr_state = CDR_FREQ;
            CDR_FREQ:
                if (lock_cnt >= 9'(FREQ_CYC - 1))
                    next_cdr_state = CDR_COARSE;
            CDR_COARSE:
                if (lock_cnt >= 9'(COARSE_CYC - 1))
                    next_cdr_state = CDR_FINE;
            CDR_FINE:
                if (fine_settled && fd_mismatch)
                    next_cdr_state = CDR_FREQ;
            default:
                next_cdr_state = CDR_OFF;
        endcase
        if (!cdr_run)
            next_cdr_state = CDR_OFF;
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            cdr_state <= CDR_OFF;
        else
            cdr_state <= next_cdr_state;
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            lock_cnt <= '0;
        else if (next_cdr_state != cdr_state)
            lock_cnt <= '0;
        else if (lock_cnt != '1)
            lock_cnt <= 9'(lock_cnt + 1'b1);
    end
    // =====================================================================
    // Status and outputs
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            pma_status_reg <= 7'h00;
        else
        begin
            pma_status_reg                <= 7'h00;
            pma_status_reg[ST_TDET_BIT]   <= tdet;
            pma_status_reg[ST_CDRLOL_BIT] <= !fine_settled;
            pma_status_reg[ST_TXLOL_BIT]  <= !txpll_lock;
            pma_status_reg[ST_REFLOL_BIT] <= cdr_state inside {CDR_OFF, CDR_FREQ};
            pma_status_reg[ST_FDMIS_BIT]  <= fine_settled && fd_mismatch;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            RECOVERED_CLOCK_RUN <= 1'b0;
            DRIFT_RANGE_WIDE    <= 1'b0;
            CDR_LOCKED          <= 1'b0;
        end
        else
        begin
            RECOVERED_CLOCK_RUN <= cdr_run;
            DRIFT_RANGE_WIDE    <= pma_control_zero[C0_DRIFT_BIT];
            CDR_LOCKED          <= fine_settled;
        end
    end
    // =====================================================================
    // Assertions
    a_path_b_route: assert property (@(posedge MCLK) disable iff (!RESETN)
        lb_b |=> RX_FIFO_DATA == $past(TX_XG_DATA))
        else $error("path B data not routed to receive FIFO");
    a_path_c_route: assert property (@(posedge MCLK) disable iff (!RESETN)
        lb_c |=> TX_FIFO_CTRL == $past(RX_DEC_CTRL))
        else $error("path C control not routed to transmit FIFO");
    a_far_loop: assert property (@(posedge MCLK) disable iff (!RESETN)
        lb_far |=> TX_SER_WORD == $past(RX_DES_WORD))
        else $error("far-end loopback word wrong");
    a_normal_path: assert property (@(posedge MCLK) disable iff (!RESETN)
        loopback_control_reg == 3'h0 |=> RX_PCS_WORD == $past(RX_DES_WORD)
            && TX_FIFO_DATA == $past(TX_XG_DATA))
        else $error("normal datapath disturbed");
    a_path_a_lat: assert property (@(posedge MCLK) disable iff (!RESETN)
        lb_a [*3] |=> RX_PCS_WORD == $past(TX_PCS_WORD, 2))
        else $error("loopback FIFO delay wrong");
    a_tdet_sticky: assert property (@(posedge MCLK) disable iff (!RESETN)
        tdet |=> tdet)
        else $error("transition detect cleared");
    a_tdet_thresh: assert property (@(posedge MCLK) disable iff (!RESETN)
        !tdet && !pma_control_zero[C0_THR_BIT] && above_125 |=> tdet)
        else $error("low threshold crossing missed");
    a_txlol_stat: assert property (@(posedge MCLK) disable iff (!RESETN)
        !txpll_lock [*2] |=> pma_status_reg[ST_TXLOL_BIT])
        else $error("transmit PLL loss-of-lock not shown");
    a_coarse_fine: assert property (@(posedge MCLK) disable iff (!RESETN)
        cdr_state == CDR_COARSE && next_cdr_state != CDR_COARSE && cdr_run
            |=> cdr_state == CDR_FINE)
        else $error("coarse lock did not step to fine");
    a_no_early_cmp: assert property (@(posedge MCLK) disable iff (!RESETN)
        $rose(cdr_state == CDR_FINE) ##0 cdr_run [*7] |=> cdr_state == CDR_FINE)
        else $error("frequency compared before settle time");
    a_relock_time: assert property (@(posedge MCLK) disable iff (!RESETN)
        $rose(cdr_state == CDR_COARSE) |-> ##[1:20] (fine_settled || !cdr_run))
        else $error("phase lock not reached in time");
    a_mismatch_back: assert property (@(posedge MCLK) disable iff (!RESETN)
        fine_settled && fd_mismatch && cdr_run |=> cdr_state == CDR_FREQ)
        else $error("mismatch did not restart acquisition");
endmodule

// [tb/sdl_far_model.sv]
// Behavioural model of the receive front end, transmit PLL and reference clock
`timescale 1ns/1ps
module sdl_far_model
(
    input  wire logic       mclk,
    input  wire logic [1:0] amp_sel,
    input  wire logic       pll_ok,
    input  wire logic       ref_ok,
    input  wire logic [7:0] dev_req,
    output logic            above_125,
    output logic            above_180,
    output logic            txpll_lock,
    output logic            refclk_ok,
    output logic [7:0]      freq_dev
);
    // ==========================================================
    // Line levels
    // Amplitude above 180 mV is also above 125 mV
    assign above_125  = (amp_sel != 2'h0);
    assign above_180  = (amp_sel == 2'h2);
    assign txpll_lock = pll_ok;
    // One reference feeds both paths, so far-end loopback never slips
    assign refclk_ok  = ref_ok;
    // Deviation is only moved on a clock edge and then held by the bench
    always_ff @(posedge mclk)
    begin
        freq_dev <= dev_req;
    end
endmodule

// [tb/test_sdl_top.sv]
// Self-checking bench for the loopback and lock status block
`timescale 1ns/1ps
module test_sdl_top import sdl_pkg::*; ();
    logic        MCLK = 0, RESETN = 0, cyc = 0, stb = 0, we = 0, ack;
    logic [3:0]  sel = 0, adr = 0;
    logic [31:0] wdat = 0, rdat, lfsr = 32'h0001_6368;
    logic [63:0] txd = 0, rxd = 0, rff_d, tff_d, note;
    logic [7:0]  txc = 0, rxc = 0, rff_c, tff_c, fdev, dev_req = 0;
    logic [15:0] tpw = 0, rdw = 0, rpw, tsw;
    logic        on_tx, a125, a180, plk, rok, run, wide, locked, pll_ok = 1, ref_ok = 1;
    logic [1:0]  amp = 0;
    logic [3:0]  cfg [8] = '{4'h8, 4'h9, 4'hA, 4'hC, 4'hF, 4'h1, 4'h2, 4'h3};
    logic [63:0] exp_q [$];
    int          num_errors = 0, comparisons = 0, cycles = 0;
    sdl_top u_dut (.MCLK(MCLK), .RESETN(RESETN), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
        .WB_SEL(sel), .WB_ADR(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK(ack),
        .TX_XG_DATA(txd), .TX_XG_CTRL(txc), .RX_DEC_DATA(rxd), .RX_DEC_CTRL(rxc),
        .RX_FIFO_DATA(rff_d), .RX_FIFO_CTRL(rff_c), .TX_FIFO_DATA(tff_d), .TX_FIFO_CTRL(tff_c),
        .TX_PCS_WORD(tpw), .RX_DES_WORD(rdw), .RX_PCS_WORD(rpw), .TX_SER_WORD(tsw),
        .RX_PATH_ON_TX_CLK(on_tx), .RX_ABOVE_125(a125), .RX_ABOVE_180(a180),
        .TXPLL_LOCK(plk), .REFCLK_OK(rok), .FREQ_DEV(fdev), .RECOVERED_CLOCK_RUN(run),
        .DRIFT_RANGE_WIDE(wide), .CDR_LOCKED(locked));
    sdl_far_model u_far (.mclk(MCLK), .amp_sel(amp), .pll_ok(pll_ok), .ref_ok(ref_ok),
        .dev_req(dev_req), .above_125(a125), .above_180(a180), .txpll_lock(plk),
        .refclk_ok(rok), .freq_dev(fdev));
    // ==========================================================
    // Helpers
    always #20 MCLK = ~MCLK;
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Ceiling leaves ample room over the four relock waits of about 400 cycles
    always @(posedge MCLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic check(input logic [71:0] seen, input logic [71:0] exp, input string name);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic void step();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    endfunction
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge MCLK);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        @(posedge MCLK);
        while (ack !== 1'b1)
            @(posedge MCLK);
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] mask);
        exp_q.push_back({mask, exp});
        wb(0, a, 32'h0000_0000, 4'hF);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic wait_lock();
        int n;
        n = 0;
        while (locked !== 1'b1 && n < 700)
        begin
            @(posedge MCLK);
            n++;
        end
        #1;
        check(locked, 1, "lock acquired");
    endtask
    // Read data is judged where the answer appears, against the oldest note
    always @(posedge MCLK)
    begin
        if (ack === 1'b1 && cyc && !we)
        begin
            note = exp_q.pop_front();
            check(rdat & note[63:32], note[31:0], "read data");
        end
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge MCLK);
        RESETN <= 1;
        rd(OFS_LOOPBACK, 32'h0, 32'h7);
        rd(OFS_PMA_CTRL0, 32'h1, 32'hF);
        rd(OFS_MODE, 32'h1, 32'h1);
        rd(OFS_PMA_STAT, 32'h28, 32'h3C);
        step();
        wb(1, OFS_LOOPBACK, lfsr, 4'hF);
        rd(OFS_LOOPBACK, {29'h0, lfsr[2:0]}, 32'h7);
        wb(1, OFS_LOOPBACK, ~lfsr, 4'h0);
        rd(OFS_LOOPBACK, {29'h0, lfsr[2:0]}, 32'h7);
        wb(1, OFS_PMA_STAT, 32'hFFFF_FFFF, 4'hF);
        wb(1, 4'h2, 32'hFFFF_FFFF, 4'hF);
        rd(4'h2, 32'h0, 32'hFFFF_FFFF);
        rd(OFS_PMA_STAT, 32'h0, 32'h14);
        $display("Test registers done");
        foreach (cfg[i])
        begin
            wb(1, OFS_MODE, {31'h0, cfg[i][3]}, 4'h1);
            wb(1, OFS_LOOPBACK, {29'h0, cfg[i][2:0]}, 4'h1);
            @(posedge MCLK);
            step();
            txd <= {lfsr, lfsr ^ 32'hA5A5_5A5A};
            txc <= lfsr[7:0];
            tpw <= lfsr[31:16];
            step();
            rxd <= {~lfsr, lfsr};
            rxc <= lfsr[15:8];
            rdw <= lfsr[15:0];
            settle(6);
            check({rff_c, rff_d}, (cfg[i][3] && cfg[i][2]) ? {txc, txd} : {rxc, rxd},
                  "rx fifo word");
            check({tff_c, tff_d}, (cfg[i][3] && cfg[i][1]) ? {rxc, rxd} : {txc, txd},
                  "tx fifo word");
            check(rpw, cfg[i][0] ? tpw : rdw, "rx pcs word");
            check(tsw, (!cfg[i][3] && cfg[i][1]) ? rdw : tpw, "tx ser word");
            check(on_tx, cfg[i][3] && cfg[i][0], "rx on tx clock");
        end
        wb(1, OFS_MODE, 32'h1, 4'h1);
        wb(1, OFS_LOOPBACK, 32'h0, 4'h1);
        $display("Test loopback done");
        wb(1, OFS_PMA_CTRL0, 32'h3, 4'h1);
        amp <= 2'h1;
        settle(8);
        rd(OFS_PMA_STAT, 32'h0, 32'h4);
        amp <= 2'h2;
        settle(3);
        amp <= 2'h0;
        settle(8);
        rd(OFS_PMA_STAT, 32'h4, 32'h4);
        // Mid-run reset clears the sticky detect so the low threshold can be tried
        RESETN <= 0;
        settle(3);
        RESETN <= 1;
        rd(OFS_PMA_STAT, 32'h0, 32'h4);
        amp <= 2'h1;
        settle(8);
        rd(OFS_PMA_STAT, 32'h4, 32'h4);
        amp <= 2'h0;
        $display("Test transition detect done");
        pll_ok <= 0;
        settle(30);
        rd(OFS_PMA_STAT, 32'h10, 32'h10);
        pll_ok <= 1;
        settle(6);
        rd(OFS_PMA_STAT, 32'h0, 32'h10);
        $display("Test transmit pll done");
        wb(1, OFS_PMA_CTRL0, 32'h5, 4'h1);
        settle(4);
        check(wide, 1, "drift range");
        check(run, 1, "recovered clock");
        wait_lock();
        rd(OFS_PMA_STAT, 32'h0, 32'h28);
        for (int s = 0; s < 2; s++)
        begin
            wb(1, OFS_PMA_CTRL0, s ? 32'hD : 32'h5, 4'h1);
            dev_req <= s ? FD_THR_SET1 : FD_THR_SET0;
            settle(20);
            check(locked, 1, "lock at threshold");
            dev_req <= s ? FD_THR_SET1 + 8'h01 : FD_THR_SET0 + 8'h01;
            settle(20);
            check(locked, 0, "lock over threshold");
            rd(OFS_PMA_STAT, 32'h20, 32'h20);
            dev_req <= 8'h00;
            wait_lock();
        end
        ref_ok <= 0;
        settle(8);
        check(run, 0, "recovered clock");
        check(locked, 0, "lock without reference");
        ref_ok <= 1;
        wait_lock();
        $display("Test clock recovery done");
        end_of_test();
    end
endmodule
